/* hdl/bfh_pkg.sv */
// Constants and types shared by both ends of the burst flash bus link
//
// Summary of operation
// - data_ready high while burst word valid, and throughout async reads
// - asynchronous reads need no clock activity
// - addr_valid_n low captures burst start address
// - addr_valid_n high ignores address_bus except while write_enable_n low latches the command address
// - hw_reset_n low returns to read array
// - write_protect_n low guards outermost sectors
// - program_accel and accel_hv: fast, lock all, or none
// - chip and output select act unclocked
// - command latches hidden from read space
// - rising burst clock edge by default
// - host read: select, output on, write off
// - reset ends burst, floats data_bus
// - new address strobe restarts burst
// - even start address gets faster first word
// - two latency cycles at 64-word boundary
// - linear modes wrap within aligned group
package bfh_pkg;
	localparam int ADDR_W = 21;
	localparam int DATA_W = 16;
	localparam int MEM_AW = 8;
	localparam int CNT_W  = 6;
	localparam int BND_W  = 6;
	localparam int SECT_LSB = 15;
	localparam int CLK_PS = 5000;
	localparam int IACC_EVEN_PS = 87500;
	localparam int IACC_ODD_PS  = 106000;
	localparam int ACC_ASYNC_PS = 70000;
	// Longest times round down, least times round up
	localparam logic [CNT_W-1:0] IACC_EVEN_CNT = CNT_W'(IACC_EVEN_PS / CLK_PS);
	localparam logic [CNT_W-1:0] IACC_ODD_CNT  = CNT_W'(IACC_ODD_PS / CLK_PS);
	localparam logic [CNT_W-1:0] ACC_ASYNC_CNT = CNT_W'((ACC_ASYNC_PS + CLK_PS - 1) / CLK_PS);
	localparam logic [CNT_W-1:0] PROG_CNT  = 6'h10;
	localparam logic [CNT_W-1:0] ACCEL_CNT = 6'h04;
	localparam logic [CNT_W-1:0] WR_CNT    = 6'h04;
	localparam logic [CNT_W-1:0] HALF_CNT  = 6'h02;
	localparam logic [1:0] BND_LAT = 2'h2;
	localparam logic [BND_W-1:0] BND_LAST  = 6'h3f;
	localparam logic [BND_W-1:0] SKIP_FROM = 6'h3e;
	localparam logic [ADDR_W-1:0] WRAP8_MASK  = 21'h000007;
	localparam logic [ADDR_W-1:0] WRAP16_MASK = 21'h00000f;
	localparam logic [ADDR_W-1:0] WRAP32_MASK = 21'h00001f;
	typedef enum logic [1:0] {BFH_CONT, BFH_LIN8, BFH_LIN16, BFH_LIN32} bfh_mode_type;
endpackage

/* hdl/bfh_flash_if.sv */
// Pin bundle between the flash device end and the host controller end
`timescale 1ns/1ps
`default_nettype none
interface bfh_flash_if;
	import bfh_pkg::*;
	logic [ADDR_W-1:0] address_bus;
	logic              chip_select_n;
	logic              output_enable_n;
	logic              write_enable_n;
	logic              addr_valid_n;
	logic              burst_clk;
	logic              hw_reset_n;
	logic              write_protect_n;
	logic              program_accel;
	logic              accel_hv;
	logic              data_ready;
	logic [DATA_W-1:0] dev_dq;
	logic              dev_dq_oe;
	logic [DATA_W-1:0] host_dq;
	logic              host_dq_oe;
	logic [DATA_W-1:0] data_bus;

	// Resolved level of the shared data wires
	assign data_bus = dev_dq_oe ? dev_dq : (host_dq_oe ? host_dq : '0);

	modport dev (
		input  address_bus, chip_select_n, output_enable_n, write_enable_n,
		input  addr_valid_n, burst_clk, hw_reset_n, write_protect_n,
		input  program_accel, accel_hv, data_bus,
		output data_ready, dev_dq, dev_dq_oe
	);
	modport host (
		output address_bus, chip_select_n, output_enable_n, write_enable_n,
		output addr_valid_n, burst_clk, hw_reset_n, write_protect_n,
		output program_accel, accel_hv, host_dq, host_dq_oe,
		input  data_bus, data_ready
	);
endinterface
`default_nettype wire

/* hdl/bfh_addr_gen.sv */
// Next burst address with group wrap and 64-word boundary flag
`timescale 1ns/1ps
`default_nettype none
module bfh_addr_gen
	import bfh_pkg::*;
(
	input  wire logic [ADDR_W-1:0] cur_addr,
	input  wire bfh_mode_type      mode,
	output logic [ADDR_W-1:0]      next_addr,
	output logic                   at_boundary
);
	logic [ADDR_W-1:0] mask;
	logic [ADDR_W-1:0] inc;

	always_comb begin
		case (mode)
			BFH_LIN8:  mask = WRAP8_MASK;
			BFH_LIN16: mask = WRAP16_MASK;
			BFH_LIN32: mask = WRAP32_MASK;
			default:   mask = '1;
		endcase
		inc = cur_addr + 1'b1;
		next_addr = (cur_addr & ~mask) | (inc & mask);
		at_boundary = (mode == BFH_CONT) && (cur_addr[BND_W-1:0] == BND_LAST);
	end
endmodule
`default_nettype wire

/* hdl/bfh_flash_dev.sv */
// Flash device end: latched reads, burst engine, command latches, programming
`timescale 1ns/1ps
`default_nettype none
module bfh_flash_dev
	import bfh_pkg::*;
(
	bfh_flash_if.dev           bus,
	input  wire logic          core_clk,
	input  wire logic          rst_b,
	input  wire logic          sync_mode,
	input  wire bfh_mode_type  burst_mode,
	input  wire logic          reduced_ws,
	input  wire logic          clk_fall,
	output logic               prog_busy,
	output logic               unlock_bypass
);
	typedef enum logic [1:0] {D_IDLE, D_INIT, D_EDGE, D_BURST} bfh_dstate_type;

	logic [DATA_W-1:0] mem [2**MEM_AW];

	bfh_dstate_type    st_reg;
	bfh_dstate_type    st_next;
	logic [ADDR_W-1:0] addr_reg;
	logic [ADDR_W-1:0] addr_next;
	logic [CNT_W-1:0]  cnt_reg;
	logic [CNT_W-1:0]  cnt_next;
	logic [1:0]        bnd_reg;
	logic [1:0]        bnd_next;
	logic              skip_reg;
	logic              skip_next;
	logic              rdy_reg;
	logic              rdy_next;
	logic [DATA_W-1:0] dout_reg;
	logic [DATA_W-1:0] dout_next;
	logic              clk_q_reg;
	logic              we_q_reg;
	logic [ADDR_W-1:0] cmd_addr_reg;
	logic [ADDR_W-1:0] cmd_addr_next;
	logic [DATA_W-1:0] cmd_data_reg;
	logic [DATA_W-1:0] cmd_data_next;
	logic [CNT_W-1:0]  pcnt_reg;
	logic [CNT_W-1:0]  pcnt_next;
	logic              pbusy_reg;
	logic              ubp_reg;
	logic              act_edge;
	logic              mem_we;
	logic              wr_end;
	logic              wr_ok;
	logic [ADDR_W-1:0] burst_next;
	logic              at_bnd;

	// Sector at either end of the array
	function automatic logic is_outer(input logic [ADDR_W-1:0] a);
		is_outer = (a[ADDR_W-1:SECT_LSB] == '0) || (a[ADDR_W-1:SECT_LSB] == '1);
	endfunction

	bfh_addr_gen bfh_addr_gen_i (
		.cur_addr    (addr_reg),
		.mode        (burst_mode),
		.next_addr   (burst_next),
		.at_boundary (at_bnd)
	);

	assign act_edge = clk_fall ? (clk_q_reg & ~bus.burst_clk) : (~clk_q_reg & bus.burst_clk);

	assign bus.dev_dq_oe = ~bus.chip_select_n & ~bus.output_enable_n & bus.write_enable_n
		& bus.hw_reset_n;
	assign bus.dev_dq     = dout_reg;
	assign bus.data_ready = rdy_reg;
	assign prog_busy      = pbusy_reg;
	assign unlock_bypass  = ubp_reg;

	assign wr_end = ~we_q_reg & bus.write_enable_n & ~bus.chip_select_n & bus.hw_reset_n
		& ~pbusy_reg;
	assign wr_ok  = bus.program_accel & ~(~bus.write_protect_n & is_outer(cmd_addr_reg));

	always_comb begin
		st_next       = st_reg;
		addr_next     = addr_reg;
		cnt_next      = cnt_reg;
		bnd_next      = bnd_reg;
		skip_next     = skip_reg;
		rdy_next      = rdy_reg;
		dout_next     = dout_reg;
		cmd_addr_next = cmd_addr_reg;
		cmd_data_next = cmd_data_reg;
		pcnt_next     = (pcnt_reg != '0) ? pcnt_reg - 1'b1 : pcnt_reg;
		mem_we        = 1'b0;
		if (!bus.hw_reset_n) begin
			st_next   = D_IDLE;
			rdy_next  = 1'b0;
			bnd_next  = '0;
			pcnt_next = '0;
		end else if (bus.chip_select_n) begin
			st_next  = D_IDLE;
			rdy_next = 1'b0;
			bnd_next = '0;
		end else begin
			if (!bus.write_enable_n) begin
				cmd_addr_next = bus.address_bus;
				cmd_data_next = bus.data_bus;
			end
			if (wr_end && wr_ok) begin
				mem_we    = 1'b1;
				pcnt_next = bus.accel_hv ? ACCEL_CNT : PROG_CNT;
			end
			if (!bus.addr_valid_n) begin
				addr_next = bus.address_bus;
				bnd_next  = '0;
				rdy_next  = ~sync_mode;
				skip_next = reduced_ws && (bus.address_bus[BND_W-1:0] >= SKIP_FROM);
				if (sync_mode) begin
					st_next = D_INIT;
					cnt_next = (reduced_ws && !bus.address_bus[0]) ? IACC_EVEN_CNT
						: IACC_ODD_CNT;
				end else begin
					st_next = D_IDLE;
				end
			end else if (!sync_mode) begin
				dout_next = mem[addr_reg[MEM_AW-1:0]];
				rdy_next  = 1'b1;
			end else begin
				case (st_reg)
					D_INIT: begin
						if (cnt_reg <= 6'h01) begin
							st_next = D_EDGE;
						end else begin
							cnt_next = cnt_reg - 1'b1;
						end
					end
					D_EDGE: begin
						if (act_edge) begin
							st_next   = D_BURST;
							rdy_next  = 1'b1;
							dout_next = mem[addr_reg[MEM_AW-1:0]];
						end
					end
					D_BURST: begin
						if (act_edge) begin
							if (bnd_reg != '0) begin
								bnd_next = bnd_reg - 1'b1;
								if (bnd_reg == 2'h1) begin
									rdy_next  = 1'b1;
									dout_next = mem[addr_reg[MEM_AW-1:0]];
								end
							end else begin
								addr_next = burst_next;
								if (at_bnd) begin
									skip_next = 1'b0;
								end
								if (at_bnd && reduced_ws && !skip_reg) begin
									bnd_next = BND_LAT;
									rdy_next = 1'b0;
								end else begin
									dout_next = mem[burst_next[MEM_AW-1:0]];
								end
							end
						end
					end
					default: begin
						st_next = D_IDLE;
					end
				endcase
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_reg       <= D_IDLE;
			addr_reg     <= '0;
			cnt_reg      <= '0;
			bnd_reg      <= '0;
			skip_reg     <= 1'b0;
			rdy_reg      <= 1'b0;
			dout_reg     <= '0;
			clk_q_reg    <= 1'b0;
			we_q_reg     <= 1'b1;
			cmd_addr_reg <= '0;
			cmd_data_reg <= '0;
			pcnt_reg     <= '0;
			pbusy_reg    <= 1'b0;
			ubp_reg      <= 1'b0;
		end else begin
			st_reg       <= st_next;
			addr_reg     <= addr_next;
			cnt_reg      <= cnt_next;
			bnd_reg      <= bnd_next;
			skip_reg     <= skip_next;
			rdy_reg      <= rdy_next;
			dout_reg     <= dout_next;
			clk_q_reg    <= bus.burst_clk;
			we_q_reg     <= bus.write_enable_n;
			cmd_addr_reg <= cmd_addr_next;
			cmd_data_reg <= cmd_data_next;
			pcnt_reg     <= pcnt_next;
			pbusy_reg    <= (pcnt_next != '0);
			ubp_reg      <= bus.accel_hv;
		end
	end

	// Array has no reset; words read undefined until programmed
	always_ff @(posedge core_clk) begin
		if (mem_we) begin
			mem[cmd_addr_reg[MEM_AW-1:0]] <= cmd_data_reg;
		end
	end
endmodule
`default_nettype wire

/* hdl/bfh_flash_host.sv */
// Host controller end: latched async reads, clocked bursts and writes
`timescale 1ns/1ps
`default_nettype none
module bfh_flash_host
	import bfh_pkg::*;
(
	bfh_flash_if.host          bus,
	input  wire logic          core_clk,
	input  wire logic          rst_b,
	input  wire logic          req_valid,
	input  wire logic          req_write,
	input  wire logic          req_burst,
	input  wire logic [ADDR_W-1:0] req_addr,
	input  wire logic [DATA_W-1:0] req_wdata,
	input  wire logic [CNT_W-1:0]  req_len,
	input  wire logic          protect_req,
	input  wire logic          accel_lock,
	input  wire logic          accel_fast,
	input  wire logic          flash_reset,
	output logic               req_ready,
	output logic [DATA_W-1:0]  rd_data,
	output logic               rd_valid
);
	typedef enum logic [2:0] {H_IDLE, H_AVD, H_AWAIT, H_BURST, H_WRITE, H_WEND} bfh_hstate_type;

	bfh_hstate_type    st_reg;
	bfh_hstate_type    st_next;
	logic [ADDR_W-1:0] addr_reg;
	logic [ADDR_W-1:0] addr_next;
	logic [DATA_W-1:0] wdata_reg;
	logic [DATA_W-1:0] wdata_next;
	logic              cs_n_reg;
	logic              cs_n_next;
	logic              oe_n_reg;
	logic              oe_n_next;
	logic              we_n_reg;
	logic              we_n_next;
	logic              avd_n_reg;
	logic              avd_n_next;
	logic              dq_oe_reg;
	logic              dq_oe_next;
	logic              clk_reg;
	logic              clk_next;
	logic              wr_reg;
	logic              wr_next;
	logic              bst_reg;
	logic              bst_next;
	logic [CNT_W-1:0]  cnt_reg;
	logic [CNT_W-1:0]  cnt_next;
	logic [CNT_W-1:0]  div_reg;
	logic [CNT_W-1:0]  div_next;
	logic [CNT_W-1:0]  left_reg;
	logic [CNT_W-1:0]  left_next;
	logic [DATA_W-1:0] rd_data_reg;
	logic [DATA_W-1:0] rd_data_next;
	logic              rd_valid_reg;
	logic              rd_valid_next;
	logic              ctl_rst_reg;
	logic              ctl_wp_reg;
	logic              ctl_acc_reg;
	logic              ctl_hv_reg;

	assign req_ready           = (st_reg == H_IDLE) && !ctl_rst_reg;
	assign rd_data             = rd_data_reg;
	assign rd_valid            = rd_valid_reg;
	assign bus.address_bus     = addr_reg;
	assign bus.host_dq         = wdata_reg;
	assign bus.host_dq_oe      = dq_oe_reg;
	assign bus.chip_select_n   = cs_n_reg;
	assign bus.output_enable_n = oe_n_reg;
	assign bus.write_enable_n  = we_n_reg;
	assign bus.addr_valid_n    = avd_n_reg;
	assign bus.burst_clk       = clk_reg;
	assign bus.hw_reset_n      = ~ctl_rst_reg;
	assign bus.write_protect_n = ~ctl_wp_reg;
	assign bus.program_accel   = ~ctl_acc_reg;
	assign bus.accel_hv        = ctl_hv_reg;

	always_comb begin
		st_next = st_reg;
		addr_next = addr_reg;
		wdata_next = wdata_reg;
		cs_n_next = cs_n_reg;
		oe_n_next = oe_n_reg;
		we_n_next = we_n_reg;
		avd_n_next = avd_n_reg;
		dq_oe_next = dq_oe_reg;
		clk_next = clk_reg;
		wr_next = wr_reg;
		bst_next = bst_reg;
		cnt_next = cnt_reg;
		div_next = div_reg;
		left_next = left_reg;
		rd_data_next = rd_data_reg;
		rd_valid_next = 1'b0;
		case (st_reg)
			H_IDLE: begin
				if (req_valid && !ctl_rst_reg) begin
					st_next = H_AVD;
					addr_next = req_addr;
					wdata_next = req_wdata;
					wr_next = req_write;
					bst_next = req_burst;
					left_next = req_len;
					cs_n_next = 1'b0;
					avd_n_next = 1'b0;
				end
			end
			H_AVD: begin
				avd_n_next = 1'b1;
				if (wr_reg) begin
					st_next = H_WRITE;
					cnt_next = WR_CNT;
					we_n_next = 1'b0;
					dq_oe_next = 1'b1;
				end else begin
					oe_n_next = 1'b0;
					div_next = '0;
					cnt_next = ACC_ASYNC_CNT;
					st_next = bst_reg ? H_BURST : H_AWAIT;
				end
			end
			H_AWAIT: begin
				cnt_next = cnt_reg - 1'b1;
				if (cnt_reg <= 6'h01) begin
					rd_data_next = bus.data_bus;
					rd_valid_next = 1'b1;
					cs_n_next = 1'b1;
					oe_n_next = 1'b1;
					st_next = H_IDLE;
				end
			end
			H_BURST: begin
				div_next = div_reg + 1'b1;
				if (div_reg >= HALF_CNT - 1'b1) begin
					div_next = '0;
					clk_next = ~clk_reg;
					// Sample ahead of the falling half, word valid only with ready
					if (clk_reg && bus.data_ready) begin
						rd_data_next = bus.data_bus;
						rd_valid_next = 1'b1;
						left_next = left_reg - 1'b1;
						if (left_reg <= 6'h01) begin
							cs_n_next = 1'b1;
							oe_n_next = 1'b1;
							clk_next = 1'b0;
							st_next = H_IDLE;
						end
					end
				end
			end
			H_WRITE: begin
				cnt_next = cnt_reg - 1'b1;
				if (cnt_reg <= 6'h01) begin
					we_n_next = 1'b1;
					st_next = H_WEND;
				end
			end
			default: begin
				cs_n_next = 1'b1;
				dq_oe_next = 1'b0;
				st_next = H_IDLE;
			end
		endcase
		if (ctl_rst_reg) begin
			st_next = H_IDLE;
			cs_n_next = 1'b1;
			oe_n_next = 1'b1;
			we_n_next = 1'b1;
			avd_n_next = 1'b1;
			dq_oe_next = 1'b0;
			clk_next = 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_reg <= H_IDLE;
			addr_reg <= '0;
			wdata_reg <= '0;
			cs_n_reg <= 1'b1;
			oe_n_reg <= 1'b1;
			we_n_reg <= 1'b1;
			avd_n_reg <= 1'b1;
			dq_oe_reg <= 1'b0;
			clk_reg <= 1'b0;
			wr_reg <= 1'b0;
			bst_reg <= 1'b0;
			cnt_reg <= '0;
			div_reg <= '0;
			left_reg <= '0;
			rd_data_reg <= '0;
			rd_valid_reg <= 1'b0;
			ctl_rst_reg <= 1'b0;
			ctl_wp_reg <= 1'b0;
			ctl_acc_reg <= 1'b0;
			ctl_hv_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			addr_reg <= addr_next;
			wdata_reg <= wdata_next;
			cs_n_reg <= cs_n_next;
			oe_n_reg <= oe_n_next;
			we_n_reg <= we_n_next;
			avd_n_reg <= avd_n_next;
			dq_oe_reg <= dq_oe_next;
			clk_reg <= clk_next;
			wr_reg <= wr_next;
			bst_reg <= bst_next;
			cnt_reg <= cnt_next;
			div_reg <= div_next;
			left_reg <= left_next;
			rd_data_reg <= rd_data_next;
			rd_valid_reg <= rd_valid_next;
			ctl_rst_reg <= flash_reset;
			ctl_wp_reg <= protect_req;
			ctl_acc_reg <= accel_lock;
			ctl_hv_reg <= accel_fast;
		end
	end
endmodule
`default_nettype wire

/* tb/bfh_link_monitor.sv */
// Pin-level checker for the link between the flash device and host ends
`timescale 1ns/1ps
`default_nettype none
module bfh_link_monitor
	import bfh_pkg::*;
(
	input  wire logic core_clk,
	input  wire logic rst_b,
	input  wire logic sync_mode,
	input  wire logic chip_select_n,
	input  wire logic output_enable_n,
	input  wire logic write_enable_n,
	input  wire logic addr_valid_n,
	input  wire logic hw_reset_n,
	input  wire logic data_ready,
	input  wire logic dev_dq_oe,
	input  wire logic host_dq_oe
);
	logic [5:0] since_reg;
	logic [5:0] since_next;

	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	// Cycles since the last accepted address strobe, saturating
	always_comb begin
		since_next = (since_reg == 6'h3f) ? since_reg : since_reg + 6'h01;
		if (!addr_valid_n && !chip_select_n) begin
			since_next = 6'h00;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			since_reg <= 6'h3f;
		end else begin
			since_reg <= since_next;
		end
	end

	sequence seq_strobe;
		sync_mode && !addr_valid_n && !chip_select_n;
	endsequence

	sequence seq_not_ready;
		!data_ready [*6];
	endsequence

	chk_reset_floats: assert property (!hw_reset_n |-> !dev_dq_oe)
		else $error("data bus driven during flash reset");
	chk_reset_ready: assert property (!hw_reset_n |=> !data_ready)
		else $error("ready high after flash reset");
	chk_standby_float: assert property (chip_select_n |-> !dev_dq_oe)
		else $error("data bus driven while deselected");
	chk_output_float: assert property (output_enable_n |-> !dev_dq_oe)
		else $error("data bus driven with outputs disabled");
	chk_read_drive: assert property (!chip_select_n && !output_enable_n && write_enable_n
		&& hw_reset_n |-> dev_dq_oe)
		else $error("device silent during read");
	chk_strobe_restart: assert property (seq_strobe |-> ##2 seq_not_ready)
		else $error("ready high right after new strobe");
	chk_first_latency: assert property ($rose(data_ready) && sync_mode |-> since_reg >= 6'h10)
		else $error("first burst word too early");
	chk_strobe_single: assert property ($fell(addr_valid_n) |=> addr_valid_n)
		else $error("address strobe longer than one cycle");
	chk_strobe_selected: assert property (!addr_valid_n |-> !chip_select_n)
		else $error("address strobe without chip select");
	chk_read_no_write: assert property (!output_enable_n |-> write_enable_n
		&& !host_dq_oe)
		else $error("host drives during read");
endmodule
`default_nettype wire

/* tb/test_burst_flash_host_bus_interface.sv */
// Self-checking bench joining the flash device end to the host end
`timescale 1ns/1ps
`default_nettype none
module test_burst_flash_host_bus_interface
	import bfh_pkg::*;
;
	logic              core_clk;
	logic              rst_b;
	logic              sync_mode;
	bfh_mode_type      burst_mode;
	logic              reduced_ws;
	logic              prog_busy;
	logic              unlock_bypass;
	logic              req_valid;
	logic              req_write;
	logic              req_burst;
	logic [ADDR_W-1:0] req_addr;
	logic [DATA_W-1:0] req_wdata;
	logic [CNT_W-1:0]  req_len;
	logic              protect_req;
	logic              accel_lock;
	logic              accel_fast;
	logic              flash_reset;
	logic              req_ready;
	logic [DATA_W-1:0] rd_data;
	logic              rd_valid;
	logic [DATA_W-1:0] exp_mem [256];
	logic [DATA_W-1:0] d;
	logic              clk_fall;
	int                cyc;
	int                lat_odd;
	int                lat_even;
	int                busy;
	int                mismatches;
	int                checks;

	bfh_flash_if bfh_flash_if_i ();

	bfh_flash_dev bfh_flash_dev_i (.bus(bfh_flash_if_i), .core_clk(core_clk), .rst_b(rst_b),
		.sync_mode(sync_mode), .burst_mode(burst_mode), .reduced_ws(reduced_ws),
		.clk_fall(clk_fall), .prog_busy(prog_busy), .unlock_bypass(unlock_bypass));

	bfh_flash_host bfh_flash_host_i (.bus(bfh_flash_if_i), .core_clk(core_clk), .rst_b(rst_b),
		.req_valid(req_valid), .req_write(req_write), .req_burst(req_burst),
		.req_addr(req_addr), .req_wdata(req_wdata), .req_len(req_len),
		.protect_req(protect_req), .accel_lock(accel_lock), .accel_fast(accel_fast),
		.flash_reset(flash_reset), .req_ready(req_ready), .rd_data(rd_data),
		.rd_valid(rd_valid));

	bfh_link_monitor bfh_link_monitor_i (.core_clk(core_clk), .rst_b(rst_b),
		.sync_mode(sync_mode), .chip_select_n(bfh_flash_if_i.chip_select_n),
		.output_enable_n(bfh_flash_if_i.output_enable_n),
		.write_enable_n(bfh_flash_if_i.write_enable_n),
		.addr_valid_n(bfh_flash_if_i.addr_valid_n), .hw_reset_n(bfh_flash_if_i.hw_reset_n),
		.data_ready(bfh_flash_if_i.data_ready), .dev_dq_oe(bfh_flash_if_i.dev_dq_oe),
		.host_dq_oe(bfh_flash_if_i.host_dq_oe));

	always #2.5 core_clk = ~core_clk;

	// Free-running cycle count for latency and spacing checks
	always @(posedge core_clk) cyc <= cyc + 1;

	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic issue(input logic wr, input logic bu, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] wd, input logic [CNT_W-1:0] len);
		int n;
		n = 0;
		while (req_ready !== 1'b1 && n < 400) begin
			@(negedge core_clk);
			n++;
		end
		if (n >= 400) begin
			mismatches++;
		end
		req_write = wr;
		req_burst = bu;
		req_addr = a;
		req_wdata = wd;
		req_len = len;
		req_valid = 1'b1;
		@(negedge core_clk);
		req_valid = 1'b0;
	endtask

	// Waits for one returned word; unknown if none arrives
	task automatic get_word(output logic [DATA_W-1:0] w);
		int n;
		n = 0;
		while (rd_valid !== 1'b1 && n < 200) begin
			@(negedge core_clk);
			n++;
		end
		w = (n < 200) ? rd_data : 'x;
		@(negedge core_clk);
	endtask

	// Counts the programming cycles that follow one write
	task automatic write_word(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] wd,
		output int cnt);
		cnt = 0;
		issue(1'b1, 1'b0, a, wd, 6'h01);
		repeat (40) begin
			@(negedge core_clk);
			cnt += int'(prog_busy === 1'b1);
		end
	endtask

	task automatic read_word(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] w);
		sync_mode = 1'b0;
		issue(1'b0, 1'b0, a, 16'h0000, 6'h01);
		get_word(w);
	endtask

	// Stall is the number of burst clock periods lost to boundary latency
	task automatic burst_check(input bfh_mode_type m, input logic [ADDR_W-1:0] a, input int len,
		input int stall, output int lat);
		logic [DATA_W-1:0] w;
		logic [ADDR_W-1:0] e;
		logic [ADDR_W-1:0] mask;
		int                t0;
		int                per;
		mask = (m == BFH_LIN8) ? WRAP8_MASK : (m == BFH_LIN16) ? WRAP16_MASK :
			(m == BFH_LIN32) ? WRAP32_MASK : '1;
		e = a;
		per = 2 * int'(HALF_CNT);
		sync_mode = 1'b1;
		burst_mode = m;
		issue(1'b0, 1'b1, a, 16'h0000, CNT_W'(len));
		t0 = cyc;
		lat = 0;
		for (int i = 0; i < len; i++) begin
			get_word(w);
			if (i == 0) begin
				lat = cyc - t0;
				t0 = cyc;
			end
			check("burst word", w, exp_mem[e[7:0]]);
			e = (e & ~mask) | ((e + 1'b1) & mask);
		end
		check("burst span", 16'(cyc - t0), 16'((len - 1 + stall) * per));
	endtask

	initial begin
		repeat (30000) @(posedge core_clk);
		mismatches++;
		wrap_up();
	end

	initial begin
		core_clk = 1'b0;
		rst_b = 1'b0;
		sync_mode = 1'b0;
		clk_fall = 1'b0;
		burst_mode = BFH_CONT;
		reduced_ws = 1'b0;
		req_valid = 1'b0;
		req_write = 1'b0;
		req_burst = 1'b0;
		req_addr = '0;
		req_wdata = '0;
		req_len = 6'h01;
		protect_req = 1'b0;
		accel_lock = 1'b0;
		accel_fast = 1'b0;
		flash_reset = 1'b0;
		repeat (20) @(negedge core_clk);
		rst_b = 1'b1;
		for (int a = 8'h20; a < 8'h48; a++) begin
			write_word(21'(a), 16'ha500 ^ 16'(a), busy);
			exp_mem[a] = 16'ha500 ^ 16'(a);
		end
		check("program time", 16'(busy), 16'(PROG_CNT));
		read_word(21'h000020, d);
		check("async read", d, exp_mem[8'h20]);
		for (int rw = 0; rw < 2; rw++) begin
			reduced_ws = rw[0];
			for (int m = 0; m < 4; m++) begin
				burst_check(bfh_mode_type'(m), 21'h00003d, 8,
					(rw == 1 && m == 0) ? int'(BND_LAT) : 0, lat_odd);
			end
		end
		burst_check(BFH_CONT, 21'h00003e, 4, 0, lat_even);
		check("even start sooner", 16'(lat_even < lat_odd), 16'h0001);
		@(negedge core_clk);
		check("standby drive", 16'(bfh_flash_if_i.dev_dq_oe), 16'h0000);
		clk_fall = 1'b1;
		burst_check(BFH_LIN16, 21'h000024, 4, 0, busy);
		clk_fall = 1'b0;
		burst_mode = BFH_CONT;
		issue(1'b0, 1'b1, 21'h000020, 16'h0000, 6'h20);
		get_word(d);
		check("burst before reset", d, exp_mem[8'h20]);
		flash_reset = 1'b1;
		repeat (3) @(negedge core_clk);
		check("reset drive", 16'(bfh_flash_if_i.dev_dq_oe), 16'h0000);
		check("reset ready", 16'(bfh_flash_if_i.data_ready), 16'h0000);
		flash_reset = 1'b0;
		read_word(21'h000021, d);
		check("read after reset", d, exp_mem[8'h21]);
		protect_req = 1'b1;
		write_word(21'h000021, 16'h1234, busy);
		check("outer low sector", 16'(busy), 16'h0000);
		write_word(21'h1f8022, 16'h1234, busy);
		check("outer high sector", 16'(busy), 16'h0000);
		write_word(21'h008023, 16'h5a5a, busy);
		exp_mem[8'h23] = 16'h5a5a;
		check("inner sector", 16'(busy), 16'(PROG_CNT));
		protect_req = 1'b0;
		accel_lock = 1'b1;
		write_word(21'h000024, 16'h1234, busy);
		check("locked program", 16'(busy), 16'h0000);
		accel_lock = 1'b0;
		accel_fast = 1'b1;
		write_word(21'h000025, 16'h7e7e, busy);
		exp_mem[8'h25] = 16'h7e7e;
		check("fast program", 16'(busy), 16'(ACCEL_CNT));
		check("unlock bypass", 16'(unlock_bypass), 16'h0001);
		accel_fast = 1'b0;
		for (int a = 8'h21; a < 8'h26; a++) begin
			read_word(21'(a), d);
			check("read back", d, exp_mem[a]);
		end
		wrap_up();
	end
endmodule
`default_nettype wire
